// ==== inc/cscd_pkg.sv ====
package cscd_pkg;
   // register addresses
   localparam logic [7:0] ADDR_SCAN_CTRL = 8'h1b;
   localparam logic [7:0] ADDR_RESET_GAIN = 8'h1c;
   localparam logic [7:0] ADDR_DRIVE_CH0 = 8'h1e;
   localparam logic [7:0] ADDR_DRIVE_CH1 = 8'h1f;
   localparam logic [7:0] ADDR_DRIVE_CH2 = 8'h20;
   localparam logic [7:0] ADDR_DRIVE_CH3 = 8'h21;
   localparam logic [7:0] ADDR_CONFIG = 8'h1a;
   // channel scan control fields
   localparam int SCAN_EN_BIT = 15;
   localparam int SCAN_ORDER_HI = 14;
   localparam int SCAN_ORDER_LO = 13;
   localparam int FILTER_HI = 2;
   localparam int FILTER_LO = 0;
   localparam logic [15:0] SCAN_CTRL_RST = 16'h020f;
   // reset and gain fields
   localparam int SOFT_RESET_BIT = 15;
   localparam int GAIN_HI = 10;
   localparam int GAIN_LO = 9;
   localparam logic [15:0] RESET_GAIN_RST = 16'h0000;
   localparam logic [15:0] RESET_GAIN_WMASK = 16'h0600;
   // drive fields
   localparam int DRIVE_HI = 15;
   localparam int DRIVE_LO = 11;
   localparam logic [15:0] DRIVE_RST = 16'h0000;
   localparam logic [15:0] DRIVE_WMASK = 16'hf800;
   // config register fields used by this block
   localparam int CHAN_SEL_HI = 15;
   localparam int CHAN_SEL_LO = 14;
   localparam int BOOST_BIT = 6;
   localparam logic [15:0] CONFIG_RST = 16'h2801;
   // scan order codes
   localparam logic [1:0] ORDER_TWO = 2'h0;
   localparam logic [1:0] ORDER_THREE = 2'h1;
   localparam logic [1:0] ORDER_FOUR = 2'h2;
   // filter bandwidth codes
   localparam logic [2:0] FILT_1MHZ = 3'h1;
   localparam logic [2:0] FILT_3MHZ3 = 3'h4;
   localparam logic [2:0] FILT_10MHZ = 3'h5;
   localparam logic [2:0] FILT_33MHZ = 3'h7;
   // gain shifts
   localparam logic [2:0] SHIFT_G1 = 3'h0;
   localparam logic [2:0] SHIFT_G4 = 3'h2;
   localparam logic [2:0] SHIFT_G8 = 3'h3;
   localparam logic [2:0] SHIFT_G16 = 3'h4;
   // timing: settle and convert intervals
   localparam int CLK_MHZ = 20;
   localparam int SETTLE_US = 1;
   localparam int CONVERT_US = 10;
   localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
   localparam int CONVERT_CYC = CONVERT_US * CLK_MHZ;
   localparam int CNT_W = 9;
   localparam int RESULT_W = 12;
   typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_CONVERT} cscd_state_e;
endpackage : cscd_pkg

// ==== design/cscd_drive_reg.sv ====
`timescale 1ns/10ps
// one channel's drive register; only the code field is storage
module cscd_drive_reg
   import cscd_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic soft_rst,
   input wire logic wr_en,
   input wire logic [15:0] wr_data,
   output logic [4:0] code_q
);
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         code_q <= 5'h00;
      else if (soft_rst)
         code_q <= DRIVE_RST[DRIVE_HI:DRIVE_LO];
      else if (wr_en)
         code_q <= wr_data[DRIVE_HI:DRIVE_LO];
   end
endmodule : cscd_drive_reg

// ==== design/cscd_sequencer.sv ====
`timescale 1ns/10ps
// picks the channel to convert and times settle and convert intervals
module cscd_sequencer
   import cscd_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic abort,
   input wire logic scan_en,
   input wire logic [1:0] scan_order,
   input wire logic [1:0] single_sel,
   input wire logic four_chan,
   output logic [1:0] chan_q,
   output logic active_q,
   output logic conv_q,
   output logic done_q
);
   cscd_state_e state_q, state_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [1:0] chan_d;
   logic [1:0] last_chan;
   logic [1:0] next_scan;
   logic scan_latched_q, scan_latched_d;
   logic [1:0] order_latched_q, order_latched_d;
   logic cfg_change;
   logic interval_end;

   assign last_chan = !four_chan ? 2'h1 :
      (order_latched_q == ORDER_THREE) ? 2'h2 :
      (order_latched_q == ORDER_FOUR) ? 2'h3 : 2'h1;
   assign next_scan = (chan_q >= last_chan) ? 2'h0 : chan_q + 2'h1;
   assign cfg_change = (scan_en != scan_latched_q) ||
      (scan_order != order_latched_q);
   assign interval_end = (state_q == ST_SETTLE) ?
      (cnt_q == CNT_W'(SETTLE_CYC - 1)) : (cnt_q == CNT_W'(CONVERT_CYC - 1));

   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q + CNT_W'(1);
      chan_d = chan_q;
      scan_latched_d = scan_latched_q;
      order_latched_d = order_latched_q;
      unique case (state_q)
         ST_IDLE:
         begin
            cnt_d = '0;
            state_d = ST_SETTLE;
            scan_latched_d = scan_en;
            order_latched_d = scan_order;
            chan_d = scan_en ? 2'h0 :
               (four_chan ? single_sel : {1'b0, single_sel[0]});
         end
         ST_SETTLE:
            if (interval_end)
            begin
               cnt_d = '0;
               state_d = ST_CONVERT;
            end
         ST_CONVERT:
            if (interval_end)
            begin
               cnt_d = '0;
               state_d = ST_SETTLE;
               scan_latched_d = scan_en;
               order_latched_d = scan_order;
               if (cfg_change)
                  chan_d = scan_en ? 2'h0 : single_sel;
               else if (scan_latched_q)
                  chan_d = next_scan;
               else
                  chan_d = single_sel;
               if (!four_chan)
                  chan_d[1] = 1'b0;
            end
      endcase
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_q <= ST_IDLE;
         cnt_q <= '0;
         chan_q <= 2'h0;
         scan_latched_q <= 1'b0;
         order_latched_q <= 2'h0;
         active_q <= 1'b0;
         conv_q <= 1'b0;
         done_q <= 1'b0;
      end
      else if (abort)
      begin
         state_q <= ST_IDLE;
         cnt_q <= '0;
         chan_q <= 2'h0;
         active_q <= 1'b0;
         conv_q <= 1'b0;
         done_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         chan_q <= chan_d;
         scan_latched_q <= scan_latched_d;
         order_latched_q <= order_latched_d;
         active_q <= (state_d != ST_IDLE);
         conv_q <= (state_d == ST_CONVERT);
         done_q <= (state_q == ST_CONVERT) && interval_end;
      end
   end
endmodule : cscd_sequencer

// ==== design/cscd_scan_drive_cfg.sv ====
`timescale 1ns/10ps
// Contract
// - With scan off the device converts continuously on the single selected channel.
// - With scan on the channel sequence follows the scan order field.
// - Scan converts each listed channel once, then restarts the order forever.
// - Order code 00/11 gives ch0-1, 01 gives ch0-2, 10 gives ch0-3 on 4-ch parts.
// - Filter field 2:0 picks 1, 3.3, 10 or 33 MHz bandwidth, reset 111.
// - Writing one to reset bit 15 resets the device; the bit reads zero.
// - On 12-bit parts the gain field left-shifts the result by 0, 2, 3 or 4.
// - A channel's drive code is applied only while it settles and converts.
// - The single select field picks channel 0 to 3, 2-3 only on 4-ch parts.
module cscd_scan_drive_cfg
   import cscd_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic four_chan,
   input wire logic narrow_result,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [RESULT_W-1:0] raw_result,
   output logic [15:0] reg_rdata_q,
   output logic [1:0] conv_chan_q,
   output logic sensor_active_q,
   output logic conv_phase_q,
   output logic conv_done_q,
   output logic [4:0] drive_code_q,
   output logic drive_en_q,
   output logic boost_q,
   output logic [2:0] filter_bw_q,
   output logic [15:0] scaled_result_q,
   output logic soft_reset_q
);
   logic [15:0] scan_ctrl_q;
   logic [1:0] gain_q;
   logic [15:0] config_q;
   logic [4:0] code_chan [4];
   logic soft_rst;
   logic hit_scan;
   logic hit_gain;
   logic hit_cfg;
   logic [3:0] hit_drive;
   logic multi_channel_scan_enable;
   logic [1:0] scan_order_select;
   logic [1:0] single_channel_select;
   logic boosted_drive_chan0;
   logic [2:0] filter_wr;
   logic [2:0] gain_shift;
   logic [15:0] shifted;
   logic [15:0] rdata_d;
   logic [1:0] seq_chan;
   logic seq_active;
   logic seq_conv;
   logic seq_done;

   assign hit_scan = reg_wr && (reg_addr == ADDR_SCAN_CTRL);
   assign hit_gain = reg_wr && (reg_addr == ADDR_RESET_GAIN);
   assign hit_cfg = reg_wr && (reg_addr == ADDR_CONFIG);
   assign hit_drive[0] = reg_wr && (reg_addr == ADDR_DRIVE_CH0);
   assign hit_drive[1] = reg_wr && (reg_addr == ADDR_DRIVE_CH1);
   assign hit_drive[2] = reg_wr && (reg_addr == ADDR_DRIVE_CH2) && four_chan;
   assign hit_drive[3] = reg_wr && (reg_addr == ADDR_DRIVE_CH3) && four_chan;
   assign soft_rst = hit_gain && reg_wdata[SOFT_RESET_BIT];

   assign multi_channel_scan_enable = scan_ctrl_q[SCAN_EN_BIT];
   assign scan_order_select = scan_ctrl_q[SCAN_ORDER_HI:SCAN_ORDER_LO];
   assign single_channel_select = config_q[CHAN_SEL_HI:CHAN_SEL_LO];
   assign boosted_drive_chan0 = config_q[BOOST_BIT];

   // unlisted filter codes keep the previous setting
   assign filter_wr = reg_wdata[FILTER_HI:FILTER_LO];

   // reserved bits 12:3 are stored as written; software keeps the pattern
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         scan_ctrl_q <= SCAN_CTRL_RST;
      else if (soft_rst)
         scan_ctrl_q <= SCAN_CTRL_RST;
      else if (hit_scan)
      begin
         scan_ctrl_q[15:3] <= reg_wdata[15:3];
         if (filter_wr == FILT_1MHZ || filter_wr == FILT_3MHZ3 ||
             filter_wr == FILT_10MHZ || filter_wr == FILT_33MHZ)
            scan_ctrl_q[FILTER_HI:FILTER_LO] <= filter_wr;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         gain_q <= 2'h0;
      else if (soft_rst)
         gain_q <= RESET_GAIN_RST[GAIN_HI:GAIN_LO];
      else if (hit_gain)
         gain_q <= reg_wdata[GAIN_HI:GAIN_LO];
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         config_q <= CONFIG_RST;
      else if (soft_rst)
         config_q <= CONFIG_RST;
      else if (hit_cfg)
         config_q <= reg_wdata;
   end

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_drive
         cscd_drive_reg u_drive (
            .clk(clk),
            .rst_b(rst_b),
            .soft_rst(soft_rst),
            .wr_en(hit_drive[gi]),
            .wr_data(reg_wdata),
            .code_q(code_chan[gi])
         );
      end
   endgenerate

   cscd_sequencer u_seq (
      .clk(clk),
      .rst_b(rst_b),
      .abort(soft_rst),
      .scan_en(multi_channel_scan_enable),
      .scan_order(scan_order_select),
      .single_sel(single_channel_select),
      .four_chan(four_chan),
      .chan_q(seq_chan),
      .active_q(seq_active),
      .conv_q(seq_conv),
      .done_q(seq_done)
   );

   assign gain_shift = (gain_q == 2'h1) ? SHIFT_G4 :
      (gain_q == 2'h2) ? SHIFT_G8 :
      (gain_q == 2'h3) ? SHIFT_G16 : SHIFT_G1;
   assign shifted = narrow_result ?
      (16'(raw_result) << gain_shift) : 16'(raw_result);

   always_comb
   begin
      rdata_d = 16'h0000;
      unique case (reg_addr)
         ADDR_SCAN_CTRL: rdata_d = scan_ctrl_q;
         ADDR_RESET_GAIN: rdata_d = {5'h00, gain_q, 9'h000};
         ADDR_CONFIG: rdata_d = config_q;
         ADDR_DRIVE_CH0: rdata_d = {code_chan[0], 11'h000};
         ADDR_DRIVE_CH1: rdata_d = {code_chan[1], 11'h000};
         ADDR_DRIVE_CH2: rdata_d = four_chan ? {code_chan[2], 11'h000} : 16'h0;
         ADDR_DRIVE_CH3: rdata_d = four_chan ? {code_chan[3], 11'h000} : 16'h0;
         default: rdata_d = 16'h0000;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         reg_rdata_q <= 16'h0000;
         conv_chan_q <= 2'h0;
         sensor_active_q <= 1'b0;
         conv_phase_q <= 1'b0;
         conv_done_q <= 1'b0;
         drive_code_q <= 5'h00;
         drive_en_q <= 1'b0;
         boost_q <= 1'b0;
         filter_bw_q <= 3'h7;
         scaled_result_q <= 16'h0000;
         soft_reset_q <= 1'b0;
      end
      else
      begin
         if (reg_rd)
            reg_rdata_q <= rdata_d;
         conv_chan_q <= seq_chan;
         sensor_active_q <= seq_active;
         conv_phase_q <= seq_conv;
         conv_done_q <= seq_done;
         drive_code_q <= seq_active ? code_chan[seq_chan] : 5'h00;
         drive_en_q <= seq_active;
         // boost honoured only off scan; unsupported combination
         boost_q <= boosted_drive_chan0 && !multi_channel_scan_enable &&
            seq_active && (seq_chan == 2'h0);
         filter_bw_q <= scan_ctrl_q[FILTER_HI:FILTER_LO];
         if (seq_done)
            scaled_result_q <= shifted;
         soft_reset_q <= soft_rst;
      end
   end
endmodule : cscd_scan_drive_cfg

// ==== sim/cscd_scan_drive_cfg_asserts.sv ====
`timescale 1ns/10ps
module cscd_scan_drive_cfg_chk
   import cscd_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic four_chan,
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [1:0] conv_chan_q,
   input wire logic sensor_active_q,
   input wire logic conv_phase_q,
   input wire logic conv_done_q,
   input wire logic [4:0] drive_code_q,
   input wire logic drive_en_q,
   input wire logic [2:0] filter_bw_q,
   input wire logic soft_reset_q
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   a_filter_write: assert property ((reg_wr && reg_addr == ADDR_SCAN_CTRL
      && reg_wdata[2:0] inside {3'h1, 3'h4, 3'h5, 3'h7})
      |=> ##1 filter_bw_q == $past(reg_wdata[2:0], 2)) else $error("filter");
   a_reset_pulse: assert property ((reg_wr && reg_addr == ADDR_RESET_GAIN
      && reg_wdata[15]) |=> soft_reset_q ##1 !soft_reset_q)
      else $error("soft reset pulse");
   a_reset_restore: assert property (soft_reset_q
      |-> ##[0:1] filter_bw_q == FILT_33MHZ) else $error("restore");
   a_drive_idle: assert property (!sensor_active_q
      |-> !drive_en_q && drive_code_q == 5'h00) else $error("drive idle");
   a_conv_inside: assert property (conv_phase_q |-> sensor_active_q)
      else $error("convert outside active");
   a_done_after: assert property ($fell(conv_phase_q) && !$past(soft_reset_q)
      |-> ##[0:1] (conv_done_q || soft_reset_q)) else $error("no done");
   a_chan_hold: assert property (conv_phase_q && $past(conv_phase_q)
      |-> $stable(conv_chan_q)) else $error("chan moved");
   a_two_chan: assert property (sensor_active_q && !four_chan
      |-> !conv_chan_q[1]) else $error("absent chan");
endmodule : cscd_scan_drive_cfg_chk

bind cscd_scan_drive_cfg cscd_scan_drive_cfg_chk u_chk (.clk(clk),
   .rst_b(rst_b), .four_chan(four_chan), .reg_wr(reg_wr),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .conv_chan_q(conv_chan_q),
   .sensor_active_q(sensor_active_q), .conv_phase_q(conv_phase_q),
   .conv_done_q(conv_done_q), .drive_code_q(drive_code_q),
   .drive_en_q(drive_en_q), .filter_bw_q(filter_bw_q),
   .soft_reset_q(soft_reset_q));

// ==== sim/cscd_host.sv ====
`timescale 1ns/10ps
// register host: strobes held one edge, released right after it
module cscd_host
(
   input wire logic clk,
   input wire logic [15:0] reg_rdata_q,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [15:0] reg_wdata
);
   initial
   begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
   end
   task wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr
   task rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata_q;
   endtask : rd
endmodule : cscd_host

// ==== sim/cscd_scan_drive_cfg_bench.sv ====
`timescale 1ns/10ps
module cscd_scan_drive_cfg_bench
   import cscd_pkg::*;
;
   logic clk = 1'b0, rst_b = 1'b0, four_chan = 1'b0, narrow_result = 1'b0;
   logic reg_wr, reg_rd;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata_q, scaled_result_q;
   logic [RESULT_W-1:0] raw_result = 12'h9c5;
   logic [1:0] conv_chan_q;
   logic sensor_active_q, conv_phase_q, conv_done_q, drive_en_q, boost_q;
   logic soft_reset_q;
   logic [4:0] drive_code_q;
   logic [2:0] filter_bw_q;
   logic [15:0] d;
   int fails = 0, tests_run = 0;
   logic [1:0] lens [4] = '{2'h2, 2'h3, 2'h0, 2'h2};
   logic [2:0] filts [4] = '{3'h1, 3'h4, 3'h5, 3'h7};
   logic [2:0] shifts [4] = '{3'h0, 3'h2, 3'h3, 3'h4};
   always #25 clk = ~clk;
   cscd_host host (.clk(clk), .reg_rdata_q(reg_rdata_q), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
   cscd_scan_drive_cfg dut (.clk(clk), .rst_b(rst_b), .four_chan(four_chan),
      .narrow_result(narrow_result), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .raw_result(raw_result),
      .reg_rdata_q(reg_rdata_q), .conv_chan_q(conv_chan_q),
      .sensor_active_q(sensor_active_q), .conv_phase_q(conv_phase_q),
      .conv_done_q(conv_done_q), .drive_code_q(drive_code_q),
      .drive_en_q(drive_en_q), .boost_q(boost_q), .filter_bw_q(filter_bw_q),
      .scaled_result_q(scaled_result_q), .soft_reset_q(soft_reset_q));
   task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         $display("ERROR %s expected %h seen %h", name, exp, seen);
         fails++;
      end
   endtask : check
   task rd_chk(input logic [7:0] a, input logic [15:0] exp);
      host.rd(a, d);
      check("reg", d, exp);
   endtask : rd_chk
   task wait_done;
      int n;
      n = 0;
      while (conv_done_q !== 1'b1 && n < 600)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      check("done", {15'h0, conv_done_q}, 16'h1);
   endtask : wait_done
   // next conversion: its channel and the drive applied meanwhile
   task conv_chk(input logic [1:0] ch);
      int n;
      n = 0;
      wait_done();
      while (conv_phase_q !== 1'b1 && n < 100)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      check("chan", {14'h0, conv_chan_q}, {14'h0, ch});
      check("drive", {10'h0, drive_en_q, drive_code_q}, {10'h1, ch, 3'h5});
   endtask : conv_chk
   task summarize;
      if (fails == 0 && tests_run > 0)
      begin
         $display("DONE - PASS");
      end
      else
      begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : summarize
   initial
   begin
      #2_000_000;
      fails++;
      summarize();
   end
   initial
   begin
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      rd_chk(ADDR_SCAN_CTRL, SCAN_CTRL_RST);
      rd_chk(ADDR_RESET_GAIN, 16'h0000);
      rd_chk(ADDR_DRIVE_CH1, 16'h0000);
      rd_chk(8'h30, 16'h0000);
      check("filter", {13'h0, filter_bw_q}, 16'h0007);
      for (int c = 0; c < 4; c++)
         host.wr(8'(ADDR_DRIVE_CH0 + c), {c[1:0], 3'h5, 11'h7ff});
      rd_chk(ADDR_DRIVE_CH2, 16'h0000);
      rd_chk(ADDR_DRIVE_CH1, 16'h6800);
      // reserved bits 12:3 always carry the fixed pattern
      host.wr(ADDR_SCAN_CTRL, 16'hc20f);
      for (int i = 0; i < 3; i++)
         conv_chk(2'(i % 2));
      @(posedge clk);
      four_chan <= 1'b1;
      // ch2/ch3 writes were refused while the part had two channels
      for (int c = 2; c < 4; c++)
         host.wr(8'(ADDR_DRIVE_CH0 + c), {c[1:0], 3'h5, 11'h000});
      rd_chk(ADDR_DRIVE_CH2, 16'ha800);
      for (int o = 0; o < 4; o++)
      begin
         host.wr(ADDR_SCAN_CTRL, 16'(16'h820f | (o << 13)));
         for (int i = 0; i <= lens[o] + (lens[o] == 0) * 4; i++)
            conv_chk(2'(i % (lens[o] == 0 ? 4 : lens[o])));
      end
      host.wr(ADDR_SCAN_CTRL, SCAN_CTRL_RST);
      for (int s = 0; s < 4; s++)
      begin
         host.wr(ADDR_CONFIG, {s[1:0], CONFIG_RST[13:0]});
         conv_chk(s[1:0]);
         conv_chk(s[1:0]);
      end
      host.wr(ADDR_CONFIG, CONFIG_RST | 16'h0040);
      conv_chk(2'h0);
      check("boost", {15'h0, boost_q}, 16'h0001);
      host.wr(ADDR_CONFIG, CONFIG_RST);
      // lowest legal bandwidth first, as a host would try them
      for (int f = 0; f < 4; f++)
      begin
         host.wr(ADDR_SCAN_CTRL, 16'h0208 | filts[f]);
         @(posedge clk);
         #1;
         check("filter", {13'h0, filter_bw_q}, {13'h0, filts[f]});
      end
      host.wr(ADDR_SCAN_CTRL, 16'h0209);
      host.wr(ADDR_SCAN_CTRL, 16'h020a);
      @(posedge clk);
      #1;
      check("filter", {13'h0, filter_bw_q}, 16'h0001);
      @(posedge clk);
      narrow_result <= 1'b1;
      for (int g = 0; g < 4; g++)
      begin
         host.wr(ADDR_RESET_GAIN, 16'(g << 9));
         rd_chk(ADDR_RESET_GAIN, 16'(g << 9));
         wait_done();
         @(posedge clk);
         #1;
         check("scaled", scaled_result_q, {4'h0, raw_result} << shifts[g]);
      end
      host.wr(ADDR_RESET_GAIN, 16'h8000);
      check("pulse", {15'h0, soft_reset_q}, 16'h0001);
      rd_chk(ADDR_RESET_GAIN, 16'h0000);
      rd_chk(ADDR_SCAN_CTRL, SCAN_CTRL_RST);
      rd_chk(ADDR_DRIVE_CH0, 16'h0000);
      summarize();
   end
endmodule : cscd_scan_drive_cfg_bench
